/* File: hdl/slpr_top.sv */
// top: link power requests, low-power link states and retained settings
// Functional notes
// R1: entering a power saving mode below idle starts a link power request
// R2: partial request only when partial enabled and host reports partial capability
// R3: slumber request only when slumber enabled and host reports slumber capability
// R4: with low power enabled, host low power requests are accepted with ack; the code acks only a request whose own mode is enabled and host capable
// R5: supported but disabled low power: every host request is refused with nak
// R6: in partial state, wake and reset out-of-band sequences are still detected
// R7: partial state holds, quiet link, until valid wake or reset arrives
// R8: in slumber state, wake and reset out-of-band sequences are still detected
// R9: slumber state holds, quiet link, until valid wake or reset arrives
// R10: link reset acts as hardware reset, including unrequested ones after signal loss
// R11: set features 06h turns retention on, 86h turns it off
// R12: retention is on by default
// R13: only settings of implemented features are kept; a strap selects support; the code uses ctrl bit CTRL_SUPALL instead and keeps all words or none
// R14: geometry, standby timer and stream error logs survive link reset
// R15: security state, frozen flag and unlock counter survive link reset
// R16: last maximum block address survives link reset
// R17: device-initiated power management enable survives link reset
// R18: write cache enable survives link reset
// R19: transfer mode selections survive link reset
// R20: advanced power management enable and level survive link reset
// R21: read look-ahead and revert-to-defaults enables survive link reset
// R22: multiple block size and sanitize frozen state survive link reset
// R23: retained storage ignores link reset while on; power-on reset restores defaults
`timescale 1ns/10ps
module slpr_top
  import slpr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // drive power state
  input wire logic deepSave,
  // link primitive events from the phy
  input wire logic hostReqPartial,
  input wire logic hostReqSlumber,
  input wire logic devAckSeen,
  input wire logic devNakSeen,
  input wire logic comWake,
  input wire logic comReset,
  // link primitive requests to the phy
  output logic sendReqPartial,
  output logic sendReqSlumber,
  output logic sendAck,
  output logic sendNak,
  output logic quietLink,
  output logic [1:0] linkState,
  output logic hwReset
);
  import slpr_pkg::*;
  slpr_link_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] feat_reg;
  logic pending_reg;
  logic prevSave_reg;
  logic wrStb;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [7:0] rdAddr;
  logic [31:0] rdWord;
  logic rdOk;
  logic wrOk;
  logic keepOn;
  logic lowEn;
  logic canPartial;
  logic canSlumber;
  logic [31:0] keepVal [0:6];
  logic [7:0] sub;
  assign keepOn = feat_reg[FT_RET] && ctrl_reg[CTRL_SUPALL]; // R13
  assign lowEn = ctrl_reg[CTRL_PARTEN] || ctrl_reg[CTRL_SLUMEN];
  assign canPartial = ctrl_reg[CTRL_PARTEN] && ctrl_reg[CTRL_HPART]; // R2
  assign canSlumber = ctrl_reg[CTRL_SLUMEN] && ctrl_reg[CTRL_HSLUM]; // R3
  assign sub = wrData[7:0];
  assign linkState = state_reg;
  assign quietLink = (state_reg != LINK_ACTIVE); // R7 R9
  assign hwReset = comReset; // R10

  slpr_axil u_bus (
    .clock(clock), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wrStb(wrStb), .wrAddr(wrAddr), .wrData(wrData), .wrOk(wrOk),
    .rdAddr(rdAddr), .rdWord(rdWord), .rdOk(rdOk)
  );

  // retained words: geometry, standby, max lo, max hi, security, transfer, stream log
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_keep
      localparam logic [7:0] OFFS = OFF_GEOM + 8'(4 * gi);
      slpr_keep_reg #(.RST_VAL(WORD_RST)) u_keep (
        .clock(clock), .reset_n(reset_n), .comReset(comReset), .keepOn(keepOn),
        .wrEn(wrStb && wrAddr == OFFS), .wrData(wrData), .value(keepVal[gi])
      ); // R14 R15 R16 R19 R23
    end
  endgenerate

  // control register, untouched by link reset; only reset_n reloads CTRL_RST
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= CTRL_RST;
    else if (wrStb && wrAddr == OFF_CTRL)
      ctrl_reg <= wrData;
  end

  // feature settings from set features subcommands
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      feat_reg <= FEAT_RST; // R12 R23
    else if (comReset && !keepOn)
      feat_reg <= FEAT_RST;
    else if (wrStb && wrAddr == OFF_CMD)
    begin
      case (sub)
        SF_RET_ON: feat_reg[FT_RET] <= 1'b1; // R11
        SF_RET_OFF: feat_reg[FT_RET] <= 1'b0; // R11
        SF_DIPM_ON: feat_reg[FT_DIPM] <= 1'b1; // R17
        SF_DIPM_OFF: feat_reg[FT_DIPM] <= 1'b0; // R17
        SF_WCE_ON: feat_reg[FT_WCE] <= 1'b1; // R18
        SF_WCE_OFF: feat_reg[FT_WCE] <= 1'b0; // R18
        SF_APM_ON:
        begin
          feat_reg[FT_APM] <= 1'b1; // R20
          feat_reg[FT_APML +: 8] <= wrData[15:8]; // R20
        end
        SF_APM_OFF: feat_reg[FT_APM] <= 1'b0; // R20
        SF_RLA_ON: feat_reg[FT_RLA] <= 1'b1; // R21
        SF_RLA_OFF: feat_reg[FT_RLA] <= 1'b0; // R21
        SF_REV_ON: feat_reg[FT_REV] <= 1'b1; // R21
        SF_REV_OFF: feat_reg[FT_REV] <= 1'b0; // R21
        default: feat_reg <= feat_reg;
      endcase
    end
    else if (wrStb && wrAddr == OFF_FEAT)
    begin
      feat_reg[FT_SANF] <= wrData[FT_SANF]; // R22
      feat_reg[FT_MULT +: 8] <= wrData[FT_MULT +: 8]; // R22
    end
  end

  // link power state
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= LINK_ACTIVE;
    else if (comReset || comWake)
      state_reg <= LINK_ACTIVE; // R6 R8
    else
    begin
      case (state_reg)
        LINK_ACTIVE:
        begin
          if ((hostReqPartial && lowEn && canPartial) || (devAckSeen && sendReqPartial))
            state_reg <= LINK_PARTIAL;
          else if ((hostReqSlumber && lowEn && canSlumber) ||
                   (devAckSeen && sendReqSlumber))
            state_reg <= LINK_SLUMBER;
        end
        LINK_PARTIAL: state_reg <= LINK_PARTIAL; // R7
        LINK_SLUMBER: state_reg <= LINK_SLUMBER; // R9
        default: state_reg <= LINK_ACTIVE;
      endcase
    end
  end

  // device-initiated requests
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pending_reg <= 1'b0;
      prevSave_reg <= 1'b0;
    end
    else
    begin
      prevSave_reg <= deepSave;
      if (comReset || comWake || devAckSeen || devNakSeen || state_reg != LINK_ACTIVE)
        pending_reg <= 1'b0;
      if (deepSave && !prevSave_reg && feat_reg[FT_DIPM] && (canPartial || canSlumber))
        pending_reg <= 1'b1; // R1
    end
  end
  assign sendReqSlumber = pending_reg && canSlumber; // R3
  assign sendReqPartial = pending_reg && !canSlumber && canPartial; // R2

  // answers to host requests
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sendAck <= 1'b0;
      sendNak <= 1'b0;
    end
    else
    begin
      sendAck <= state_reg == LINK_ACTIVE && !comReset && !comWake &&
                 ((hostReqPartial && lowEn && canPartial) ||
                  (hostReqSlumber && lowEn && canSlumber)); // R4
      sendNak <= state_reg == LINK_ACTIVE && !comReset && !comWake &&
                 ((hostReqPartial && !(lowEn && canPartial)) ||
                  (hostReqSlumber && !(lowEn && canSlumber))); // R5
    end
  end

  // register decode
  always_comb
  begin
    rdOk = 1'b1;
    case (rdAddr)
      OFF_CTRL: rdWord = ctrl_reg;
      OFF_STATUS: rdWord = {28'h0000000, pending_reg, keepOn, state_reg};
      OFF_FEAT: rdWord = feat_reg;
      OFF_CMD: rdWord = 32'h0000_0000;
      OFF_GEOM: rdWord = keepVal[0];
      OFF_STBY: rdWord = keepVal[1];
      OFF_MAXLO: rdWord = keepVal[2];
      OFF_MAXHI: rdWord = keepVal[3];
      OFF_SEC: rdWord = keepVal[4];
      OFF_XFER: rdWord = keepVal[5];
      OFF_SLOG: rdWord = keepVal[6];
      default:
      begin
        rdWord = 32'h0000_0000;
        rdOk = 1'b0;
      end
    endcase
  end
  assign wrOk = wrAddr <= OFF_SLOG && wrAddr != OFF_STATUS && wrAddr[1:0] == 2'b00;

  // checks
  property p_part_hold;
    @(posedge clock) disable iff (!reset_n)
    (state_reg == LINK_PARTIAL && !comWake && !comReset) |=> state_reg == LINK_PARTIAL;
  endproperty
  a_part_hold: assert property (p_part_hold) else $error("partial left early"); // R7
  property p_slum_hold;
    @(posedge clock) disable iff (!reset_n)
    (state_reg == LINK_SLUMBER && !comWake && !comReset) |=> state_reg == LINK_SLUMBER;
  endproperty
  a_slum_hold: assert property (p_slum_hold) else $error("slumber left early"); // R9
  property p_wake;
    @(posedge clock) disable iff (!reset_n)
    (state_reg != LINK_ACTIVE && (comWake || comReset)) |=> state_reg == LINK_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not detected"); // R6
  property p_nak;
    @(posedge clock) disable iff (!reset_n)
    (state_reg == LINK_ACTIVE && !comReset && !comWake && hostReqSlumber && !lowEn)
      |=> sendNak && !sendAck;
  endproperty
  a_nak: assert property (p_nak) else $error("disabled request not refused"); // R5
  property p_ack;
    @(posedge clock) disable iff (!reset_n)
    sendAck |-> $past(lowEn);
  endproperty
  a_ack: assert property (p_ack) else $error("ack while disabled"); // R4
  property p_reqp;
    @(posedge clock) disable iff (!reset_n)
    sendReqPartial |-> ctrl_reg[CTRL_PARTEN] && ctrl_reg[CTRL_HPART];
  endproperty
  a_reqp: assert property (p_reqp) else $error("partial request not allowed"); // R2
  property p_reqs;
    @(posedge clock) disable iff (!reset_n)
    sendReqSlumber |-> ctrl_reg[CTRL_SLUMEN] && ctrl_reg[CTRL_HSLUM];
  endproperty
  a_reqs: assert property (p_reqs) else $error("slumber request not allowed"); // R3
  property p_keep;
    @(posedge clock) disable iff (!reset_n)
    (comReset && keepOn && !wrStb) |=> $stable(feat_reg) && $stable(keepVal[4]);
  endproperty
  a_keep: assert property (p_keep) else $error("setting lost on link reset"); // R15
  property p_start;
    @(posedge clock) disable iff (!reset_n)
    (deepSave && !prevSave_reg && feat_reg[FT_DIPM] && canSlumber && !comReset)
      |=> pending_reg;
  endproperty
  a_start: assert property (p_start) else $error("no device request"); // R1
  c_part: cover property (@(posedge clock) disable iff (!reset_n)
    state_reg == LINK_PARTIAL ##1 state_reg == LINK_ACTIVE);
  c_slum: cover property (@(posedge clock) disable iff (!reset_n)
    state_reg == LINK_SLUMBER);
  c_nak: cover property (@(posedge clock) disable iff (!reset_n) sendNak);
  c_keep: cover property (@(posedge clock) disable iff (!reset_n) comReset && keepOn);
endmodule : slpr_top

/* File: include/slpr_pkg.sv */
// package: register map, encodings and reset values for link power and setting retention
package slpr_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FEAT = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_GEOM = 8'h10;
  localparam logic [7:0] OFF_STBY = 8'h14;
  localparam logic [7:0] OFF_MAXLO = 8'h18;
  localparam logic [7:0] OFF_MAXHI = 8'h1C;
  localparam logic [7:0] OFF_SEC = 8'h20;
  localparam logic [7:0] OFF_XFER = 8'h24;
  localparam logic [7:0] OFF_SLOG = 8'h28;
  // ctrl bit positions
  localparam int CTRL_PARTEN = 0;
  localparam int CTRL_SLUMEN = 1;
  localparam int CTRL_HPART = 2;
  localparam int CTRL_HSLUM = 3;
  localparam int CTRL_LPSUP = 4;
  localparam int CTRL_SUPALL = 5;
  // set features subcommands
  localparam logic [7:0] SF_WCE_ON = 8'h02;
  localparam logic [7:0] SF_XFER = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_RET_ON = 8'h06;
  localparam logic [7:0] SF_DIPM_ON = 8'h10;
  localparam logic [7:0] SF_RLA_ON = 8'h55;
  localparam logic [7:0] SF_REV_OFF = 8'h66;
  localparam logic [7:0] SF_WCE_OFF = 8'h82;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_RET_OFF = 8'h86;
  localparam logic [7:0] SF_DIPM_OFF = 8'h90;
  localparam logic [7:0] SF_RLA_OFF = 8'hAA;
  localparam logic [7:0] SF_REV_ON = 8'hCC;
  // feat register bit positions
  localparam int FT_RET = 0;
  localparam int FT_DIPM = 1;
  localparam int FT_WCE = 2;
  localparam int FT_APM = 3;
  localparam int FT_RLA = 4;
  localparam int FT_REV = 5;
  localparam int FT_SANF = 6;
  localparam int FT_APML = 8;
  localparam int FT_MULT = 16;
  // reset values of retained settings, and axi response codes
  localparam logic [31:0] FEAT_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL_RST = 32'h0000_0030;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LINK_ACTIVE, LINK_PARTIAL, LINK_SLUMBER} slpr_link_t;
endpackage : slpr_pkg

/* File: hdl/slpr_keep_reg.sv */
// one retained 32-bit setting word
`timescale 1ns/10ps
module slpr_keep_reg
  import slpr_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000
)
(
  // clock and resets
  input wire logic clock,
  input wire logic reset_n,
  input wire logic comReset,
  input wire logic keepOn,
  // update
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  // value
  output logic [31:0] value
);
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      value <= RST_VAL;
    else if (comReset && !keepOn)
      value <= RST_VAL;
    else if (wrEn)
      value <= wrData;
  end
endmodule : slpr_keep_reg

/* File: hdl/slpr_axil.sv */
// axi4-lite slave front end, one word per register
`timescale 1ns/10ps
module slpr_axil
  import slpr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // axi write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wrStb,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  input wire logic wrOk,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdWord,
  input wire logic rdOk
);
  logic awHave_reg;
  logic wHave_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  assign awready = !awHave_reg && !bvalid;
  assign wready = !wHave_reg && !bvalid;
  assign arready = !rvalid;
  assign wrStb = awHave_reg && wHave_reg && !bvalid && (wStrb_reg == 4'hF);
  assign wrAddr = awAddr_reg;
  assign wrData = wData_reg;
  assign rdAddr = araddr;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (bvalid)
    begin
      if (bready)
        bvalid <= 1'b0;
    end
    else if (awHave_reg && wHave_reg)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      bvalid <= 1'b1;
      bresp <= (wrOk && wStrb_reg == 4'hF) ? RESP_OKAY : RESP_SLVERR;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
    end
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (rvalid)
    begin
      if (rready)
        rvalid <= 1'b0;
    end
    else if (arvalid)
    begin
      rvalid <= 1'b1;
      rdata <= rdOk ? rdWord : 32'h0000_0000;
      rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end
  end
endmodule : slpr_axil

/* File: sim/slpr_host_model.sv */
// host-side model: answers device link power requests after a chosen lag
`timescale 1ns/10ps
module slpr_host_model
  import slpr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bench control
  input wire logic [3:0] lag,
  input wire logic refuse,
  // device requests
  input wire logic sendReqPartial,
  input wire logic sendReqSlumber,
  // answers
  output logic devAckSeen,
  output logic devNakSeen
);
  logic [3:0] waitCnt;
  // one answer per request, and only while a request stands
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitCnt <= 4'h0;
      devAckSeen <= 1'h0;
      devNakSeen <= 1'h0;
    end
    else
    begin
      devAckSeen <= 1'h0;
      devNakSeen <= 1'h0;
      if (!(sendReqPartial || sendReqSlumber) || devAckSeen || devNakSeen)
        waitCnt <= 4'h0;
      else if (waitCnt == lag)
      begin
        devAckSeen <= !refuse;
        devNakSeen <= refuse;
        waitCnt <= 4'h0;
      end
      else
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : slpr_host_model

/* File: sim/tb.sv */
// testbench: link power handshakes and settings kept through link reset
`timescale 1ns/10ps
module tb;
  import slpr_pkg::*;
  logic clock = 1'h0, reset_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, r, feat, rngState = 32'h0001_51C7;
  logic [3:0] wstrb = 4'h0, lag = 4'h2;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic deepSave = 1'h0, hostReqPartial = 1'h0, hostReqSlumber = 1'h0, refuse = 1'h0;
  logic comWake = 1'h0, comReset = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, devAckSeen, devNakSeen, a, n, h;
  logic sendReqPartial, sendReqSlumber, sendAck, sendNak, quietLink, hwReset;
  logic [1:0] bresp, rresp, linkState, resp;
  logic [7:0] subs [11] = '{SF_WCE_OFF, SF_APM_OFF, SF_RLA_OFF, SF_REV_OFF, SF_DIPM_OFF,
    SF_XFER, SF_WCE_ON, SF_APM_ON, SF_RLA_ON, SF_REV_ON, SF_DIPM_ON};
  logic [7:0] offs [7] = '{OFF_GEOM, OFF_STBY, OFF_MAXLO, OFF_MAXHI, OFF_SEC, OFF_XFER, OFF_SLOG};
  logic [31:0] vals [7];
  int fails = 0, n_checks = 0;
  initial
  begin
    forever #2.5 clock = !clock;
  end
  slpr_top u_slpr_top (.clock(clock), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .deepSave(deepSave), .hostReqPartial(hostReqPartial), .hostReqSlumber(hostReqSlumber),
    .devAckSeen(devAckSeen), .devNakSeen(devNakSeen), .comWake(comWake), .comReset(comReset),
    .sendReqPartial(sendReqPartial), .sendReqSlumber(sendReqSlumber), .sendAck(sendAck),
    .sendNak(sendNak), .quietLink(quietLink), .linkState(linkState), .hwReset(hwReset));
  slpr_host_model u_slpr_host_model (.clock(clock), .reset_n(reset_n), .lag(lag),
    .refuse(refuse), .sendReqPartial(sendReqPartial), .sendReqSlumber(sendReqSlumber),
    .devAckSeen(devAckSeen), .devNakSeen(devNakSeen));
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : rnd
  // feature word after one set features subcommand
  function automatic logic [31:0] featAfter(input logic [31:0] f, input logic [7:0] s,
    input logic [7:0] c);
    logic [31:0] g;
    g = f;
    case (s)
      SF_RET_ON: g[FT_RET] = 1'h1;
      SF_RET_OFF: g[FT_RET] = 1'h0;
      SF_DIPM_ON: g[FT_DIPM] = 1'h1;
      SF_DIPM_OFF: g[FT_DIPM] = 1'h0;
      SF_WCE_ON: g[FT_WCE] = 1'h1;
      SF_WCE_OFF: g[FT_WCE] = 1'h0;
      SF_APM_ON: g = {f[31:16], c, f[7:4], 1'h1, f[2:0]};
      SF_APM_OFF: g[FT_APM] = 1'h0;
      SF_RLA_ON: g[FT_RLA] = 1'h1;
      SF_RLA_OFF: g[FT_RLA] = 1'h0;
      SF_REV_ON: g[FT_REV] = 1'h1;
      SF_REV_OFF: g[FT_REV] = 1'h0;
      default: g = f;
    endcase
    return g;
  endfunction : featAfter
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic axw(input logic [7:0] ad, input logic [31:0] v, input logic [3:0] s);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clock);
    awaddr <= ad;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw))
    begin
      @(posedge clock);
      if (awvalid && awready === 1'h1)
      begin
        ta = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready === 1'h1)
      begin
        tw = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1)
      @(posedge clock);
    resp = bresp;
    bready <= 1'h0;
  endtask : axw
  task automatic axr(input logic [7:0] ad);
    @(posedge clock);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clock); while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : axr
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    axw(ad, v, 4'hF);
    chk(resp, RESP_OKAY);
  endtask : wr
  task automatic rdChk(input logic [7:0] ad, input logic [31:0] exp);
    axr(ad);
    chk(resp, RESP_OKAY);
    chk(d, exp);
  endtask : rdChk
  // one-cycle host event: 0 partial req, 1 slumber req, 2 wake, 3 link reset
  task automatic hostPulse(input int k);
    @(posedge clock);
    hostReqPartial <= (k == 0);
    hostReqSlumber <= (k == 1);
    comWake <= (k == 2);
    comReset <= (k == 3);
    #1;
    h = hwReset;
    @(posedge clock);
    {hostReqPartial, hostReqSlumber, comWake, comReset} <= 4'h0;
    #1;
    a = sendAck;
    n = sendNak;
  endtask : hostPulse
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    feat = FEAT_RST;
    rdChk(OFF_CTRL, CTRL_RST);
    rdChk(OFF_FEAT, FEAT_RST);
    axr(8'h40);
    chk(resp, RESP_SLVERR);
    axw(OFF_STATUS, 32'h0, 4'hF);
    chk(resp, RESP_SLVERR);
    axw(OFF_GEOM, 32'h1, 4'h3);
    chk(resp, RESP_SLVERR);
    for (int k = 0; k < 2; k++)
    begin
      hostPulse(k);
      chk({a, n}, 2'h1);
      chk(linkState, 2'h0);
    end
    wr(OFF_CTRL, 32'h35);
    hostPulse(1);
    chk({a, n}, 2'h1);
    for (int k = 0; k < 2; k++)
    begin
      wr(OFF_CTRL, 32'h3F);
      hostPulse(k);
      chk({a, n, linkState}, {2'h2, 2'(k + 1)});
      repeat (5 + rnd() % 16) @(posedge clock);
      hostPulse(1 - k);
      chk({a, n, linkState, quietLink}, {2'h0, 2'(k + 1), 1'h1});
      hostPulse(2 + k);
      chk({linkState, quietLink}, 3'h0);
      if (k == 1)
        chk(h, 1'h1);
    end
    wr(OFF_CMD, {24'h0, SF_DIPM_ON});
    feat = featAfter(feat, SF_DIPM_ON, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      wr(OFF_CTRL, (k == 1) ? 32'h35 : 32'h3F);
      @(posedge clock);
      refuse <= (k == 2);
      lag <= 4'h2 + 4'(rnd() % 8);
      deepSave <= 1'h1;
      repeat (2) @(posedge clock);
      #1;
      chk({sendReqPartial, sendReqSlumber}, (k == 1) ? 2'h2 : 2'h1);
      do @(posedge clock); while (devAckSeen !== 1'h1 && devNakSeen !== 1'h1);
      #1;
      chk(linkState, (k == 2) ? 2'h0 : 2'(2 - k));
      @(posedge clock);
      deepSave <= 1'h0;
      if (k < 2)
        hostPulse(2);
    end
    r = rnd();
    wr(OFF_FEAT, r);
    feat = (feat & ~32'h00FF_0040) | (r & 32'h00FF_0040);
    for (int i = 0; i < 11; i++)
    begin
      r = rnd();
      wr(OFF_CMD, {16'h0, r[7:0], subs[i]});
      feat = featAfter(feat, subs[i], r[7:0]);
    end
    for (int i = 0; i < 7; i++)
    begin
      vals[i] = rnd();
      wr(offs[i], vals[i]);
    end
    hostPulse(3);
    for (int i = 0; i < 7; i++)
      rdChk(offs[i], vals[i]);
    rdChk(OFF_FEAT, feat);
    wr(OFF_CMD, {24'h0, SF_RET_OFF});
    rdChk(OFF_FEAT, featAfter(feat, SF_RET_OFF, 8'h00));
    wr(OFF_CMD, {24'h0, SF_RET_ON});
    rdChk(OFF_FEAT, feat);
    wr(OFF_CMD, {24'h0, SF_RET_OFF});
    hostPulse(3);
    for (int i = 0; i < 7; i++)
      rdChk(offs[i], WORD_RST);
    rdChk(OFF_FEAT, FEAT_RST);
    wr(OFF_CTRL, 32'h1F);
    rdChk(OFF_STATUS, 32'h0);
    wr(OFF_GEOM, rnd());
    hostPulse(3);
    rdChk(OFF_GEOM, WORD_RST);
    wr(OFF_GEOM, rnd());
    @(posedge clock);
    reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    rdChk(OFF_GEOM, WORD_RST);
    wrap_up();
  end
endmodule : tb
